// file: hw/plb_regs.sv
`timescale 1ns/1ps
module plb_regs #(
  parameter int         MS_TICK_CYCLES = plb_pkg::MS_TICK_CYCLES_DFLT,
  parameter logic [6:0] DEV_ADDR       = 7'h2a  // arbitrary default
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [2:0]  bucksInReg,
  input  wire logic [1:0]  linearInReg,
  input  wire logic [1:0]  switchRailInReg,
  input  wire logic [1:0]  switchRailIsSwitch,
  input  wire logic        goStrobe,
  input  wire logic        goDisable,
  input  wire logic        rampDone,
  output logic             railsGoodOut,
  output logic             railsGoodOutOe,
  output logic [2:0]       buckExternalAdjust,
  output logic [11:0]      buckOneMv,
  output logic [11:0]      buckTwoMv,
  output logic [11:0]      buckThreeMv,
  output logic             transitionBusy
);
  import plb_pkg::*;
  localparam int DIVW = $clog2(MS_TICK_CYCLES + 1);
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(MS_TICK_CYCLES - 1);

  logic       wrStb, txnEnd;
  logic [7:0] wrAddr, wrData, rdAddr, rdData;

  plb_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .scl     (scl),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .wrStb   (wrStb),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .txnEnd  (txnEnd)
  );

  // register file, unlock and buck setpoints
  logic [7:0]  keyReg, keyNext, statusReg, statusNext, ctrlReg, ctrlNext;
  logic        keyInTxnReg, keyInTxnNext, keyUsedReg, keyUsedNext, busyReg, busyNext;
  logic [7:0]  buckReg [3];
  logic [7:0]  buckNext [3];
  logic [11:0] mvReg [3];
  logic [11:0] mvNext [3];
  logic        unlocked, protAddr;
  logic [1:0]  wrIdx;

  assign protAddr = (wrAddr >= ADDR_CTRL) && (wrAddr <= ADDR_BUCK3);
  // open only in the transaction after the key, and only for one write
  assign unlocked = (keyReg == UNLOCK_KEY) && !keyInTxnReg && !keyUsedReg;
  assign wrIdx    = 2'(wrAddr - ADDR_BUCK1);

  always_comb begin
    keyNext = keyReg; keyInTxnNext = keyInTxnReg; keyUsedNext = keyUsedReg;
    ctrlNext = ctrlReg; busyNext = busyReg;
    for (int i = 0; i < 3; i++) begin
      buckNext[i] = buckReg[i];
      mvNext[i]   = mvReg[i];
    end
    statusNext = statusReg;
    statusNext[ST_BUCK +: 3] = bucksInReg;
    statusNext[ST_LIN1] = linearInReg[1];
    statusNext[ST_LIN2] = linearInReg[0];
    statusNext[ST_SW1] = switchRailInReg[1] | switchRailIsSwitch[1];
    statusNext[ST_SW2] = switchRailInReg[0] | switchRailIsSwitch[0];
    if (txnEnd) begin
      if (keyInTxnReg) keyInTxnNext = 1'b0;
      else begin
        keyNext = RST_UNLOCK;
        keyUsedNext = 1'b0;
      end
    end
    if (wrStb) begin
      if (wrAddr == ADDR_UNLOCK) begin
        keyNext = wrData;
        keyInTxnNext = (wrData == UNLOCK_KEY);
        keyUsedNext = 1'b0;
      end else if (wrAddr == ADDR_STATUS) statusNext[ST_RSVD] = wrData[ST_RSVD];
      else if (protAddr && unlocked) begin
        keyUsedNext = 1'b1;
        if (wrAddr == ADDR_CTRL) ctrlNext = wrData;
        else begin
          buckNext[wrIdx] = wrData;
          if (goDisable) mvNext[wrIdx] = plb_code_to_mv(wrData[BK_CODE_MSB:0]);
        end
      end
    end
    if (goStrobe && !goDisable) begin
      for (int i = 0; i < 3; i++) mvNext[i] = plb_code_to_mv(buckReg[i][BK_CODE_MSB:0]);
    end
    for (int i = 0; i < 3; i++) begin
      if (buckReg[i][BK_XADJ]) mvNext[i] = 12'h000;
    end
    if (rampDone) busyNext = 1'b0;
    if (goStrobe) busyNext = 1'b1;  // set wins over ramp done
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      keyReg <= RST_UNLOCK; keyInTxnReg <= 1'b0; keyUsedReg <= 1'b0;
      statusReg <= RST_STATUS; ctrlReg <= RST_CTRL; busyReg <= 1'b0;
      buckReg[0] <= RST_BUCK1; buckReg[1] <= RST_BUCK2; buckReg[2] <= RST_BUCK3;
      mvReg[0] <= plb_code_to_mv(RST_BUCK1[BK_CODE_MSB:0]);
      mvReg[1] <= plb_code_to_mv(RST_BUCK2[BK_CODE_MSB:0]);
      mvReg[2] <= plb_code_to_mv(RST_BUCK3[BK_CODE_MSB:0]);
    end else begin
      keyReg <= keyNext; keyInTxnReg <= keyInTxnNext; keyUsedReg <= keyUsedNext;
      statusReg <= statusNext; ctrlReg <= ctrlNext; busyReg <= busyNext;
      for (int i = 0; i < 3; i++) begin
        buckReg[i] <= buckNext[i];
        mvReg[i]   <= mvNext[i];
      end
    end
  end

  always_comb begin
    case (rdAddr)
      ADDR_UNLOCK: rdData = keyReg;
      ADDR_STATUS: rdData = statusReg;
      ADDR_CTRL:   rdData = ctrlReg;
      ADDR_BUCK1:  rdData = buckReg[0];
      ADDR_BUCK2:  rdData = buckReg[1];
      ADDR_BUCK3:  rdData = buckReg[2];
      default:     rdData = 8'h00;
    endcase
  end

  // power-good output timer
  logic [DIVW-1:0] divReg, divNext;
  logic [8:0]      msCntReg, msCntNext, dlyMs;
  logic            oeReg, oeNext, goodAll;

  assign goodAll = &{statusReg[ST_SW1:ST_BUCK],
                     statusReg[ST_LIN1] | ctrlReg[CT_LIN1_MASK],
                     statusReg[ST_LIN2] | ctrlReg[CT_LIN2_MASK]};

  always_comb begin
    case (ctrlReg[CT_DLY_LSB +: 2])
      2'h0:    dlyMs = DLY0_MS;
      2'h1:    dlyMs = DLY1_MS;
      2'h2:    dlyMs = DLY2_MS;
      default: dlyMs = DLY3_MS;
    endcase
    divNext = divReg;
    msCntNext = msCntReg;
    // divider restarts with the statuses so the delay is never cut short
    if (!goodAll) begin
      divNext = '0;
      msCntNext = 9'h000;
    end else if (divReg == DIV_LAST) begin
      divNext = '0;
      if (msCntReg < dlyMs) msCntNext = msCntReg + 9'h001;
    end else divNext = divReg + DIVW'(1);
    oeNext = !(goodAll && (msCntReg >= dlyMs));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divReg <= '0; msCntReg <= 9'h000; oeReg <= 1'b1; railsGoodOut <= 1'b0;
    end else begin
      divReg <= divNext; msCntReg <= msCntNext; oeReg <= oeNext; railsGoodOut <= 1'b0;
    end
  end

  assign railsGoodOutOe     = oeReg;
  assign buckExternalAdjust = {buckReg[2][BK_XADJ], buckReg[1][BK_XADJ], buckReg[0][BK_XADJ]};
  assign buckOneMv          = mvReg[0];
  assign buckTwoMv          = mvReg[1];
  assign buckThreeMv        = mvReg[2];
  assign transitionBusy     = busyReg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_KEY_CLEAR: assert property (txnEnd && !keyInTxnReg |=> keyReg == RST_UNLOCK)
    else $error("unlock register not cleared after transaction");
  AST_LOCKED_DROP: assert property (wrStb && wrAddr == ADDR_CTRL && !unlocked |=> $stable(ctrlReg))
    else $error("locked write changed control register");
  AST_UNLOCKED_WRITE: assert property (wrStb && wrAddr == ADDR_CTRL && unlocked |=> ctrlReg == $past(wrData))
    else $error("unlocked write not taken");
  AST_BUCK_GOOD: assert property (1'b1 |=> statusReg[4:2] == $past(bucksInReg))
    else $error("buck status bits wrong");
  AST_LIN_GOOD: assert property (1'b1 |=> statusReg[1:0] == $past(linearInReg))
    else $error("linear status bits wrong");
  AST_SW_GOOD: assert property (1'b1 |=>
    statusReg[ST_SW1:ST_SW2] == $past(switchRailInReg | switchRailIsSwitch))
    else $error("switch rail status not high in switch mode");
  AST_LIN1_MASK: assert property (!ctrlReg[3] && !statusReg[1] |=> railsGoodOutOe)
    else $error("linear one low did not pull good output");
  AST_LIN2_MASK: assert property (!ctrlReg[2] && !statusReg[0] |=> railsGoodOutOe)
    else $error("linear two low did not pull good output");
  AST_DELAY: assert property ($fell(railsGoodOutOe) |-> $past(msCntReg) == $past(dlyMs) && $past(goodAll))
    else $error("good output released before delay");
  AST_GO_APPLY: assert property (goStrobe && !goDisable && !buckReg[0][7]
    |=> buckOneMv == plb_code_to_mv($past(buckReg[0][5:0])))
    else $error("go did not apply buck one code");
  AST_XADJ: assert property (buckReg[1][BK_XADJ] |=> buckTwoMv == 12'h000)
    else $error("external adjust did not override code");
endmodule : plb_regs

// file: hw/plb_pkg.sv
// Behaviour
// - writing key 0x7d to the unlock register opens one following protected write.
// - any other unlock value keeps every protected register locked.
// - unlock register returns to zero when the transaction after the key write ends.
// - status bits 4..2 show the three bucks in regulation.
// - status bits 1..0 show linear regulators one and two in regulation.
// - status bit 6 is high when switch rail one regulates or is a load switch.
// - status bit 5 is high when switch rail two regulates or is a load switch.
// - control bit 3 clear lets linear one status pull the good output low.
// - control bit 2 clear lets linear two status pull the good output low.
// - control bits 1:0 pick good output delay of 20, 100, 200 or 400 ms.
// - buck bit 7 set means external setpoint; the register code is then ignored.
// - buck code maps monotonically from 0.9 V to 3.3 V, saturating from 0x38.
// - new buck code applies on go strobe, or at once with go disabled if the register had bit 7 clear; busy ends on ramp done.
package plb_pkg;
  localparam logic [7:0] ADDR_UNLOCK = 8'h0b;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_CTRL   = 8'h0d;
  localparam logic [7:0] ADDR_BUCK1  = 8'h0e;
  localparam logic [7:0] ADDR_BUCK2  = 8'h0f;
  localparam logic [7:0] ADDR_BUCK3  = 8'h10;
  localparam logic [7:0] UNLOCK_KEY  = 8'h7d;
  localparam logic [7:0] RST_UNLOCK  = 8'h00;
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_CTRL    = 8'h0c;
  localparam logic [7:0] RST_BUCK1   = 8'h18;
  localparam logic [7:0] RST_BUCK2   = 8'h18;
  localparam logic [7:0] RST_BUCK3   = 8'h08;
  localparam int ST_RSVD = 7;
  localparam int ST_SW1  = 6;
  localparam int ST_SW2  = 5;
  localparam int ST_BUCK = 2;
  localparam int ST_LIN1 = 1;
  localparam int ST_LIN2 = 0;
  localparam int CT_LIN1_MASK = 3;
  localparam int CT_LIN2_MASK = 2;
  localparam int CT_DLY_LSB   = 0;
  localparam int BK_XADJ      = 7;
  localparam int BK_CODE_MSB  = 5;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS         = 1000000;
  localparam int MS_TICK_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam logic [8:0] DLY0_MS = 9'h014;  // 20 ms
  localparam logic [8:0] DLY1_MS = 9'h064;  // 100 ms
  localparam logic [8:0] DLY2_MS = 9'h0c8;  // 200 ms
  localparam logic [8:0] DLY3_MS = 9'h190;  // 400 ms
  localparam logic [5:0] SEG1_CODE = 6'h18;
  localparam logic [5:0] SEG2_CODE = 6'h30;
  localparam logic [5:0] SEG3_CODE = 6'h35;
  localparam logic [5:0] MAX_CODE  = 6'h38;
  localparam int MV_BASE = 900;
  localparam int MV_SEG1 = 1500;
  localparam int MV_SEG2 = 2700;
  localparam int MV_SEG3 = 3000;
  localparam int MV_MAX  = 3300;
  localparam int STEP_FINE = 25;
  localparam int STEP_MID  = 50;
  localparam int STEP_WIDE = 100;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_DEV, I2C_DEVACK, I2C_RX, I2C_RXACK, I2C_TX, I2C_TXACK
  } plb_i2c_state_t;

  // piecewise linear code to millivolts, the step widens twice above 1.5 V
  function automatic logic [11:0] plb_code_to_mv(input logic [5:0] c);
    if (c < SEG1_CODE) return 12'(MV_BASE + STEP_FINE * int'(c));
    if (c < SEG2_CODE) return 12'(MV_SEG1 + STEP_MID * int'(c - SEG1_CODE));
    if (c < SEG3_CODE) return 12'(MV_SEG2 + STEP_MID * int'(c - SEG2_CODE));
    if (c < MAX_CODE) return 12'(MV_SEG3 + STEP_WIDE * int'(c - SEG3_CODE));
    return 12'(MV_MAX);
  endfunction : plb_code_to_mv
endpackage : plb_pkg

// file: hw/plb_i2c_slave.sv
`timescale 1ns/1ps
module plb_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary default
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            wrStb,
  output logic [7:0]      wrAddr,
  output logic [7:0]      wrData,
  output logic [7:0]      rdAddr,
  input  wire logic [7:0] rdData,
  output logic            txnEnd
);
  import plb_pkg::*;
  plb_i2c_state_t stReg, stNext;
  logic [3:0] cntReg, cntNext;
  logic [7:0] shReg, shNext, adrReg, adrNext, waReg, waNext, wdReg, wdNext;
  logic       sclReg, sdaReg, oeReg, oeNext, haveReg, haveNext, rdReg, rdNext;
  logic       actReg, actNext, nackReg, nackNext, wsReg, wsNext, teReg, teNext;
  logic       sclRise, sclFall, startCond, stopCond;

  assign sclRise   = scl & ~sclReg;
  assign sclFall   = ~scl & sclReg;
  assign startCond = scl & sclReg & sdaReg & ~sdaIn;
  assign stopCond  = scl & sclReg & ~sdaReg & sdaIn;

  always_comb begin
    stNext = stReg; cntNext = cntReg; shNext = shReg; adrNext = adrReg;
    waNext = waReg; wdNext = wdReg; oeNext = oeReg; haveNext = haveReg;
    rdNext = rdReg; actNext = actReg; nackNext = nackReg;
    wsNext = 1'b0;
    teNext = 1'b0;
    if (startCond) begin
      stNext = I2C_DEV; cntNext = 4'h0; haveNext = 1'b0; oeNext = 1'b0;
    end else if (stopCond) begin
      // repeated start keeps one transaction; only stop ends it
      stNext = I2C_IDLE; oeNext = 1'b0; teNext = actReg; actNext = 1'b0;
    end else if (sclRise) begin
      case (stReg)
        I2C_DEV, I2C_RX: begin
          shNext = {shReg[6:0], sdaIn}; cntNext = cntReg + 4'h1;
        end
        I2C_TX: cntNext = cntReg + 4'h1;
        I2C_TXACK: nackNext = sdaIn;
        default: ;
      endcase
    end else if (sclFall) begin
      case (stReg)
        I2C_DEV: if (cntReg == 4'h8) begin
          if (shReg[7:1] == DEV_ADDR) begin
            stNext = I2C_DEVACK; oeNext = 1'b1; rdNext = shReg[0]; actNext = 1'b1;
          end else stNext = I2C_IDLE;
        end
        I2C_DEVACK: begin
          cntNext = 4'h0;
          if (rdReg) begin
            stNext = I2C_TX; shNext = rdData; oeNext = ~rdData[7]; adrNext = adrReg + 8'h01;
          end else begin
            stNext = I2C_RX; oeNext = 1'b0;
          end
        end
        I2C_RX: if (cntReg == 4'h8) begin
          stNext = I2C_RXACK; oeNext = 1'b1; cntNext = 4'h0;
          if (haveReg) begin
            wsNext = 1'b1; waNext = adrReg; wdNext = shReg; adrNext = adrReg + 8'h01;
          end else begin
            adrNext = shReg; haveNext = 1'b1;
          end
        end
        I2C_RXACK: begin
          stNext = I2C_RX; oeNext = 1'b0;
        end
        I2C_TX: if (cntReg == 4'h8) begin
          stNext = I2C_TXACK; oeNext = 1'b0;
        end else begin
          shNext = {shReg[6:0], 1'b0}; oeNext = ~shReg[6];
        end
        I2C_TXACK: if (!nackReg) begin
          stNext = I2C_TX; cntNext = 4'h0; shNext = rdData; oeNext = ~rdData[7];
          adrNext = adrReg + 8'h01;
        end else begin
          stNext = I2C_IDLE; oeNext = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stReg <= I2C_IDLE; cntReg <= 4'h0; shReg <= 8'h00; adrReg <= 8'h00;
      waReg <= 8'h00; wdReg <= 8'h00; oeReg <= 1'b0; haveReg <= 1'b0;
      rdReg <= 1'b0; actReg <= 1'b0; nackReg <= 1'b1; wsReg <= 1'b0;
      teReg <= 1'b0; sclReg <= 1'b1; sdaReg <= 1'b1; sdaOut <= 1'b0;
    end else begin
      stReg <= stNext; cntReg <= cntNext; shReg <= shNext; adrReg <= adrNext;
      waReg <= waNext; wdReg <= wdNext; oeReg <= oeNext; haveReg <= haveNext;
      rdReg <= rdNext; actReg <= actNext; nackReg <= nackNext; wsReg <= wsNext;
      teReg <= teNext; sclReg <= scl; sdaReg <= sdaIn; sdaOut <= 1'b0;
    end
  end

  assign sdaOe  = oeReg;
  assign wrStb  = wsReg;
  assign wrAddr = waReg;
  assign wrData = wdReg;
  assign rdAddr = adrReg;
  assign txnEnd = teReg;
endmodule : plb_i2c_slave

// file: test/plb_host_model.sv
`timescale 1ns/1ps
module plb_host_model
  import plb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary, must match the device
) (
  input  wire logic       sys_clk,
  input  wire logic       sdaWire,
  output logic            scl,
  output logic            sdaDrv,
  output logic            rdStrobe,
  output logic [7:0]      rdByte
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b0;
    rdStrobe = 1'b0;
    rdByte = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hold
  // data moves only while scl is low; sdaDrv high pulls the line low, released it floats to the pull-up
  task automatic clk_bit(input logic b, output logic s);
    hold(3);
    sdaDrv = ~b;
    hold(4);
    scl = 1'b1;
    hold(2);
    s = sdaWire;
    hold(3);
    scl = 1'b0;
  endtask : clk_bit
  // serves as start from idle and as repeated start with scl low
  task automatic start_c();
    hold(3);
    sdaDrv = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sdaDrv = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    hold(3);
    sdaDrv = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sdaDrv = 1'b0;
    hold(6);
  endtask : stop_c
  task automatic send_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
  endtask : send_byte
  task automatic recv_byte(input logic last);
    logic s;
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      v[i] = s;
    end
    clk_bit(last, s);
    rdByte = v;
    rdStrobe = 1'b1;
    hold(1);
    rdStrobe = 1'b0;
  endtask : recv_byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start_c();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    send_byte(d);
    stop_c();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    start_c();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    start_c();
    send_byte({DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) recv_byte(k == n - 1);
    stop_c();
  endtask : rd
  // the key goes in its own transaction, right before each protected write
  task automatic unlock();
    wr(ADDR_UNLOCK, UNLOCK_KEY);
  endtask : unlock
endmodule : plb_host_model

// file: test/pmic_lock_powergood_buck_regs_tb.sv
`timescale 1ns/1ps
module pmic_lock_powergood_buck_regs_tb;
  import plb_pkg::*;
  localparam int TICK = 10;
  logic        sys_clk, rstn, scl, hostDrv, sdaOutW, sdaOeW, rdStrobe;
  logic        goStrobe, goDisable, rampDone, railsGoodOut, railsGoodOutOe, transitionBusy;
  logic [7:0]  rdByte, expHead, ctrl;
  logic [2:0]  bucksInReg, buckExternalAdjust;
  logic [1:0]  linearInReg, switchRailInReg, switchRailIsSwitch;
  logic [11:0] buckOneMv, buckTwoMv, buckThreeMv;
  logic [31:0] rnd;
  logic [5:0]  code, lastCode [3];
  logic [7:0]  expQ [$];
  int          n_fail, n_compared, bk;
  int          dlyMs [4] = '{20, 100, 200, 400};
  wire logic   sdaWire = ~hostDrv & ~(sdaOeW & ~sdaOutW);

  plb_regs #(.MS_TICK_CYCLES(TICK), .DEV_ADDR(7'h2a)) uut (.sys_clk(sys_clk), .rstn(rstn), .scl(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOutW), .sdaOe(sdaOeW), .bucksInReg(bucksInReg), .linearInReg(linearInReg),
    .switchRailInReg(switchRailInReg), .switchRailIsSwitch(switchRailIsSwitch), .goStrobe(goStrobe),
    .goDisable(goDisable), .rampDone(rampDone), .railsGoodOut(railsGoodOut), .railsGoodOutOe(railsGoodOutOe),
    .buckExternalAdjust(buckExternalAdjust), .buckOneMv(buckOneMv), .buckTwoMv(buckTwoMv),
    .buckThreeMv(buckThreeMv), .transitionBusy(transitionBusy));
  plb_host_model #(.DEV_ADDR(7'h2a)) host (.sys_clk(sys_clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(hostDrv),
    .rdStrobe(rdStrobe), .rdByte(rdByte));

  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // setpoint table: 25 mV steps to 1.5 V, 50 mV to 3.0 V, then 100 mV, flat from 0x38
  function automatic logic [11:0] mv_of(input logic [5:0] c);
    int v;
    if (c < 6'h18) v = 900 + 25 * int'(c);
    else if (c < 6'h35) v = 1500 + 50 * (int'(c) - 24);
    else if (c < 6'h38) v = 3000 + 100 * (int'(c) - 53);
    else v = 3300;
    return 12'(v);
  endfunction : mv_of
  function automatic logic [11:0] mv_sel(input int b);
    return (b == 0) ? buckOneMv : (b == 1) ? buckTwoMv : buckThreeMv;
  endfunction : mv_sel
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic expect_rd(input logic [7:0] a, input logic [7:0] v);
    expQ.push_back(v);
    host.rd(a, 1);
  endtask : expect_rd

  // every byte the host reads is matched against the oldest note
  always @(posedge sys_clk) begin
    if (rdStrobe === 1'b1) begin
      expHead = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
      n_compared++;
      if (rdByte !== expHead) begin
        n_fail++;
        $display("FAIL %0t read %h expected %h", $time, rdByte, expHead);
      end
    end
  end

  initial begin
    #500000;
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    rstn = 1'b0;
    goStrobe = 1'b0;
    goDisable = 1'b1;
    rampDone = 1'b0;
    {bucksInReg, linearInReg, switchRailInReg, switchRailIsSwitch} = 9'h000;
    rnd = 32'hd237;
    n_fail = 0;
    n_compared = 0;
    lastCode = '{6'h18, 6'h18, 6'h08};
    cyc(5);
    rstn = 1'b1;
    cyc(4);
    chk(railsGoodOutOe, 1'b1);
    chk(buckOneMv, mv_of(6'h18));
    chk(buckThreeMv, mv_of(6'h08));
    expQ = '{RST_UNLOCK, RST_STATUS, RST_CTRL, RST_BUCK1, RST_BUCK2, RST_BUCK3};
    host.rd(ADDR_UNLOCK, 6);
    host.wr(ADDR_CTRL, 8'h00);
    expect_rd(ADDR_CTRL, RST_CTRL);
    host.unlock();
    expect_rd(ADDR_UNLOCK, UNLOCK_KEY);
    expect_rd(ADDR_UNLOCK, 8'h00);
    host.wr(ADDR_BUCK1, 8'h01);
    expect_rd(ADDR_BUCK1, RST_BUCK1);
    for (int i = 0; i < 4; i++) begin
      ctrl = (i == 0) ? 8'h00 : (i == 1) ? 8'h7c : (i == 2) ? 8'h7e : 8'hff;
      host.wr(ADDR_UNLOCK, ctrl);
      host.wr(ADDR_BUCK2, 8'h01);
      expect_rd(ADDR_BUCK2, RST_BUCK2);
    end
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      code = (i == 0) ? 6'h00 : (i == 1) ? 6'h38 : (i == 2) ? 6'h3f : rnd[5:0];
      bk = i % 3;
      lastCode[bk] = code;
      host.unlock();
      host.wr(8'(ADDR_BUCK1 + bk), {2'b00, code});
      cyc(2);
      chk(mv_sel(bk), mv_of(code));
      expect_rd(8'(ADDR_BUCK1 + bk), {2'b00, code});
    end
    host.unlock();
    host.wr(ADDR_BUCK2, 8'h85);
    cyc(2);
    chk(buckExternalAdjust, 3'b010);
    chk(buckTwoMv, 12'h000);
    goDisable = 1'b0;
    host.unlock();
    host.wr(ADDR_BUCK3, 8'h20);
    cyc(2);
    chk(buckThreeMv, mv_of(lastCode[2]));
    goStrobe = 1'b1;
    cyc(1);
    goStrobe = 1'b0;
    cyc(1);
    chk(buckThreeMv, mv_of(6'h20));
    chk(transitionBusy, 1'b1);
    rampDone = 1'b1;
    cyc(1);
    rampDone = 1'b0;
    cyc(1);
    chk(transitionBusy, 1'b0);
    // the spare status bit is plain storage and must survive the live bits around it
    host.wr(ADDR_STATUS, 8'h80);
    repeat (6) begin
      rnd = xs(rnd);
      {bucksInReg, linearInReg, switchRailInReg, switchRailIsSwitch} = rnd[8:0];
      cyc(3);
      expect_rd(ADDR_STATUS, {1'b1, switchRailInReg[1] | switchRailIsSwitch[1],
        switchRailInReg[0] | switchRailIsSwitch[0], bucksInReg, linearInReg});
    end
    // odd delay codes mask linear one, even ones linear two
    for (int d = 0; d < 4; d++) begin
      {bucksInReg, linearInReg, switchRailInReg, switchRailIsSwitch} = 9'h03c;
      ctrl = 8'(((d % 2) ? 8'h08 : 8'h04) | d);
      host.unlock();
      host.wr(ADDR_CTRL, ctrl);
      expect_rd(ADDR_CTRL, ctrl);
      chk(railsGoodOutOe, 1'b1);
      bucksInReg = 3'b111;
      cyc(dlyMs[d] * TICK - 15);
      chk(railsGoodOutOe, 1'b1);
      cyc(30);
      chk(railsGoodOutOe, 1'b0);
      chk(railsGoodOut, 1'b0);
      linearInReg[(d % 2) ? 1 : 0] = 1'b0;
      cyc(10);
      chk(railsGoodOutOe, 1'b0);
      linearInReg = 2'b00;
      cyc(3);
      chk(railsGoodOutOe, 1'b1);
    end
    cyc(20);
    chk(12'(expQ.size()), 12'h000);
    wrap_up();
  end
endmodule : pmic_lock_powergood_buck_regs_tb
